//--- bench/rdf_host_model.sv
// Bus host on the far side of the fault register
module rdf_host_model
  import rdf_pkg::*;
(
  input  wire logic     i_core_clk,
  input  wire logic     i_sda_oe,
  output rdf_bus_pins_t o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_r;  // Clock level
  logic pull_r; // Host pulls data low
  // Open drain: low if any party pulls, else pull-up
  assign o_bus = {scl_r, ~(pull_r | i_sda_oe)};
  // Idle bus; no channel masks to set up here
  initial begin
    scl_r = 1'h1;
    pull_r = 1'h0;
  end
  // One pin phase of 8 core cycles
  task automatic hp();
    repeat (8) @(posedge i_core_clk);
    #1;
  endtask
  // Start, also used as repeated start
  task automatic sta();
    pull_r = 1'h0;
    hp();
    scl_r = 1'h1;
    hp();
    pull_r = 1'h1;
    hp();
    scl_r = 1'h0;
    hp();
  endtask
  // Stop: data rises while clock high
  task automatic sto();
    pull_r = 1'h1;
    hp();
    scl_r = 1'h1;
    hp();
    pull_r = 1'h0;
    hp();
  endtask
  // Data set while clock low, sampled in the high phase
  task automatic bit_io(input logic b, output logic r);
    pull_r = ~b;
    hp();
    scl_r = 1'h1;
    hp();
    r = o_bus.sda;
    scl_r = 1'h0;
    hp();
  endtask
  // Byte MSB first, then the acknowledge bit
  task automatic byte_io(input logic [7:0] d, input logic a,
                         output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, k);
  endtask
  // Read byte, optional master ACK for a second byte
  task automatic rd(input logic [6:0] adr, input logic [7:0] cmd,
                    input int n, output logic [7:0] d0,
                    output logic [7:0] d1, output logic [2:0] ak);
    logic [7:0] x;
    sta();
    byte_io({adr, 1'h0}, 1'h1, x, ak[2]);
    byte_io(cmd, 1'h1, x, ak[1]);
    sta();
    byte_io({adr, 1'h1}, 1'h1, x, ak[0]);
    byte_io(8'hFF, n == 1, d0, x[0]);
    d1 = d0;
    if (n > 1) byte_io(8'hFF, 1'h1, d1, x[0]);
    sto();
  endtask
  // Receive byte: read back with the last command kept
  task automatic rcv(input logic [6:0] adr, output logic [7:0] d0,
                     output logic [2:0] ak);
    logic [7:0] x;
    sta();
    byte_io({adr, 1'h1}, 1'h1, x, ak[0]);
    byte_io(8'hFF, 1'h1, d0, x[0]);
    ak[2:1] = 2'h0;
    sto();
  endtask
endmodule

//--- bench/tb_remote_diode_fault_status.sv
`include "rdf_cfg.svh"
module tb_remote_diode_fault_status
  import rdf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk, rst_n, oe, sdo, mst;
  rdf_bus_pins_t    bus;   // Resolved bus pins
  rdf_diode_flags_t dio;   // Front-end flags
  logic [7:0]       stat, d0, d1;
  logic [2:0]       chan, ak, c;
  int               fails, total_checks;
  rdf_fault_status u_rdf_fault_status (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .i_diode(dio),
    .o_sda_out(sdo), .o_sda_oe(oe), .o_fault_status(stat),
    .o_meas_chan(chan), .o_meas_start(mst));
  rdf_host_model u_rdf_host_model (
    .i_core_clk(clk), .i_sda_oe(oe), .o_bus(bus));
  // Core clock, 10 ns
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Expected register: channel n on bit n, ends clear
  function automatic logic [7:0] ex(rdf_diode_flags_t f);
    return {1'h0, f.diode_open | f.anode_high, 1'h0};
  endfunction
  // Next slot: local always, faulted remotes skipped
  function automatic logic [2:0] nx(logic [2:0] n, logic [5:0] fl);
    for (int i = 0; i < 7; i++) begin
      n = (n == 3'h6) ? 3'h0 : n + 3'h1;
      if (n == 3'h0 || !fl[n - 3'h1]) return n;
    end
    return 3'h0;
  endfunction
  // Byte compare
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Three-bit compare
  task automatic chk3(input logic [2:0] g, input logic [2:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Flags change after an edge, then settle past sync
  task automatic setd(rdf_diode_flags_t f);
    @(posedge clk);
    #1;
    dio = f;
    repeat (5) @(posedge clk);
    #1;
  endtask
  // Bounded wait for a slot start pulse
  task automatic wst();
    for (int i = 0; i < 150; i++) begin
      @(posedge clk);
      #1;
      if (mst === 1'h1) return;
    end
    fails++;
    end_sim();
  endtask
  task automatic rd(logic [6:0] a, logic [7:0] cmd, int n);
    u_rdf_host_model.rd(a, cmd, n, d0, d1, ak);
  endtask
  // Hang guard
  initial begin
    #1_000_000;
    fails++;
    end_sim();
  end
  // Main sequence
  initial begin
    logic [6:0] bad;
    rdf_diode_flags_t f;
    fails = 0;
    total_checks = 0;
    rst_n = 1'h0;
    dio = '1;
    void'($urandom(32'h5669));
    repeat (8) @(posedge clk);
    #1;
    chk8(stat, `RDF_FAULT_RST);
    chk3({2'h0, oe}, 3'h0);
    rst_n = 1'h1;
    // Each flag alone, others cleared
    for (int n = 0; n < 12; n++) begin
      f = '0;
      f[n] = 1'h1;
      setd(f);
      chk8(stat, ex(f));
    end
    // Random flags read over the bus, one or two bytes
    for (int k = 0; k < 8; k++) begin
      f = 12'($urandom);
      setd(f);
      rd(`RDF_BUS_ADDR, `RDF_FAULT_CMD, 1 + k % 2);
      chk3(ak, 3'h0);
      chk8(d0, ex(f));
      chk8(d1, ex(f));
    end
    // Receive byte reuses the fault command pointer
    u_rdf_host_model.rcv(`RDF_BUS_ADDR, d0, ak);
    chk3(ak, 3'h0);
    chk8(d0, ex(f));
    // Foreign addresses: single-bit flips, then random
    for (int k = 0; k < 10; k++) begin
      bad = (k < 7) ? `RDF_BUS_ADDR ^ (7'h01 << k) : 7'($urandom);
      if (bad == `RDF_BUS_ADDR) bad = ~bad;
      rd(bad, `RDF_FAULT_CMD, 1);
      chk3(ak, 3'h7);
      chk8(d0, 8'hFF);
    end
    rd(`RDF_BUS_ADDR, 8'h00, 1);
    chk8(d0, `RDF_UNMAPPED_DATA);
    chk3(ak, 3'h0);
    chk3({2'h0, sdo}, 3'h0);
    // Slot order with none, all and random faults
    for (int p = 0; p < 3; p++) begin
      f = (p == 0) ? 12'h000 : (p == 1) ? 12'hFC0 : 12'($urandom);
      setd(f);
      wst();
      c = chan;
      repeat (8) begin
        wst();
        chk3(chan, nx(c, f.diode_open | f.anode_high));
        c = chan;
      end
    end
    end_sim();
  end
endmodule

//--- rtl/rdf_cfg.svh
`ifndef RDF_CFG_SVH
`define RDF_CFG_SVH

// Seven-bit bus address, A7..A1 = 1001101
`define RDF_BUS_ADDR        7'h4D
// Command code that selects the diode fault status register
`define RDF_FAULT_CMD       8'h36
// Fault register reset value
`define RDF_FAULT_RST       8'h00
// Field positions of the fault register
`define RDF_FAULT_LSB       1
`define RDF_RSVD_LO_BIT     0
`define RDF_RSVD_HI_BIT     7
// Byte returned for a command that selects no register here
`define RDF_UNMAPPED_DATA   8'h00
// Dwell time of one measurement slot, and core clock period
`define RDF_SLOT_TIME_NS    1000
`define RDF_CLK_PERIOD_NS   10
`define RDF_SLOT_CYCLES     (`RDF_SLOT_TIME_NS / `RDF_CLK_PERIOD_NS)

`endif

//--- rtl/rdf_fault_status.sv
// Operation
// - Channel 1 open/anode-high sets bit 1
// - Channel 2 open/anode-high sets bit 2
// - Channel 3 open/anode-high sets bit 3
// - Channel 4 open/anode-high sets bit 4
// - Channel 5 open/anode-high sets bit 5
// - Channel 6 open/anode-high sets bit 6
// - Answer only bus address 1001101
// - Sequencer skips channels with diode fault
`include "rdf_cfg.svh"

module rdf_fault_status
  import rdf_pkg::*;
#(
  parameter int N_CH = 6
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire rdf_bus_pins_t    i_bus,
  input  wire rdf_diode_flags_t i_diode,
  output logic                  o_sda_out,
  output logic                  o_sda_oe,
  output logic [7:0]            o_fault_status,
  output logic [2:0]            o_meas_chan,
  output logic                  o_meas_start
);

  // Register has room for six remote channels only
  if (N_CH != 6)
    $error("rdf_fault_status: N_CH must be 6");

  logic [1:0]      pin_s1_r;    // Bus pin sync, first stage
  logic [1:0]      pin_s2_r;    // Bus pin sync, second stage
  logic [1:0]      pin_d_r;     // Previous synced pins
  logic [11:0]     dio_s1_r;    // Diode flag sync, first stage
  logic [11:0]     dio_s2_r;    // Diode flag sync, second stage
  logic [7:0]      fault_r;     // Diode fault status register
  wire  [7:0]      fault_nxt;   // Next fault register value
  rdf_state_t      st_r;        // Slave state
  rdf_state_t      st_nxt;      // Next slave state
  logic [3:0]      cnt_r;       // Bit counter
  logic [7:0]      sh_r;        // Shift register
  logic [7:0]      ptr_r;       // Command pointer
  logic            ack_ok_r;    // Master acked last byte

  wire scl      = pin_s2_r[1];
  wire sda      = pin_s2_r[0];
  wire scl_rise = scl && !pin_d_r[1];
  wire scl_fall = !scl && pin_d_r[1];
  wire start_c  = scl && pin_d_r[1] && !sda && pin_d_r[0];
  wire stop_c   = scl && pin_d_r[1] && sda && !pin_d_r[0];
  wire byte_end = scl_fall && cnt_r == 4'h8;
  wire addr_hit = sh_r[7:1] == `RDF_BUS_ADDR;
  wire [7:0] rd_data = (ptr_r == `RDF_FAULT_CMD) ? fault_r
                                                 : `RDF_UNMAPPED_DATA;
  wire [5:0] chan_fault = dio_s2_r[11:6] | dio_s2_r[5:0];

  // Two-stage synchronisers for pins and front-end flags
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pin_s1_r <= 2'h3;
      pin_s2_r <= 2'h3;
      pin_d_r  <= 2'h3;
      dio_s1_r <= 12'h000;
      dio_s2_r <= 12'h000;
    end else begin
      pin_s1_r <= {i_bus.scl, i_bus.sda};
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
      dio_s1_r <= {i_diode.diode_open, i_diode.anode_high};
      dio_s2_r <= dio_s1_r;
    end
  end

  // Next fault bits per channel, reserved bits held low
  for (genvar g = 0; g < N_CH; g++) begin : g_fault
    // Open or anode high
    assign fault_nxt[g + `RDF_FAULT_LSB] = chan_fault[g];
    a_fault_bit_track: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $past(i_rst_n, 1) && $past(i_rst_n, 2) && $past(i_rst_n, 3)
      |-> fault_r[g + `RDF_FAULT_LSB] ==
        ($past(i_diode.diode_open[g], 3) ||
         $past(i_diode.anode_high[g], 3))) // also
      else $error("fault bit does not follow its channel");
  end
  assign fault_nxt[`RDF_RSVD_LO_BIT] = 1'b0;
  assign fault_nxt[`RDF_RSVD_HI_BIT] = 1'b0;

  // Whole fault register in one flop bank, cleared at reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      fault_r <= `RDF_FAULT_RST;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  // Next slave state
  always_comb begin
    st_nxt = st_r;
    if (stop_c) begin
      st_nxt = RDF_ST_IDLE;
    end else if (start_c) begin
      st_nxt = RDF_ST_ADDR;
    end else if (scl_fall) begin
      unique case (st_r)
        RDF_ST_ADDR: begin
          if (cnt_r == 4'h8) begin
            // Foreign address: stay off the bus
            st_nxt = addr_hit ? RDF_ST_ADDR_AK : RDF_ST_IGNORE;
          end
        end
        RDF_ST_ADDR_AK: begin
          st_nxt = sh_r[0] ? RDF_ST_TX : RDF_ST_CMD;
        end
        RDF_ST_CMD: begin
          if (cnt_r == 4'h8) begin
            st_nxt = RDF_ST_CMD_AK;
          end
        end
        RDF_ST_CMD_AK: begin
          st_nxt = RDF_ST_IGNORE;
        end
        RDF_ST_TX: begin
          if (cnt_r == 4'h8) begin
            st_nxt = RDF_ST_TX_AK;
          end
        end
        RDF_ST_TX_AK: begin
          st_nxt = ack_ok_r ? RDF_ST_TX : RDF_ST_IGNORE;
        end
        RDF_ST_IDLE,
        RDF_ST_IGNORE: begin
          st_nxt = st_r;
        end
      endcase
    end
  end

  // State, shifter and data pin driver
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_r      <= RDF_ST_IDLE;
      cnt_r     <= 4'h0;
      sh_r      <= 8'h00;
      ptr_r     <= 8'h00;
      ack_ok_r  <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      o_sda_out <= 1'b0;
      if (stop_c || start_c) begin
        // Bus conditions release the line
        cnt_r    <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        // Sample receive bits and master ack
        if (st_r == RDF_ST_ADDR || st_r == RDF_ST_CMD) begin
          sh_r  <= {sh_r[6:0], sda};
          cnt_r <= cnt_r + 4'h1;
        end
        if (st_r == RDF_ST_TX_AK) begin
          ack_ok_r <= !sda;
        end
      end else if (scl_fall) begin
        unique case (st_nxt)
          RDF_ST_ADDR_AK,
          RDF_ST_CMD_AK: begin
            // Drive ack low
            o_sda_oe <= 1'b1;
            cnt_r    <= 4'h0;
            if (st_r == RDF_ST_CMD) begin
              ptr_r <= sh_r;
            end
          end
          RDF_ST_TX: begin
            // Shift out, reload at byte start
            if (st_r != RDF_ST_TX) begin
              o_sda_oe <= !rd_data[7];
              sh_r     <= {rd_data[6:0], 1'b0};
              cnt_r    <= 4'h1;
            end else begin
              o_sda_oe <= !sh_r[7];
              sh_r     <= {sh_r[6:0], 1'b0};
              cnt_r    <= cnt_r + 4'h1;
            end
          end
          default: begin
            o_sda_oe <= 1'b0;
            if (st_r != st_nxt) begin
              cnt_r <= 4'h0;
            end
          end
        endcase
      end
    end
  end

  assign o_fault_status = fault_r;

  // Measurement sequencer, skipping faulty diodes
  rdf_sequencer #(
    .N_CH     (N_CH),
    .SLOT_CYC (`RDF_SLOT_CYCLES)
  ) u_seq (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_fault    (fault_r[N_CH:`RDF_FAULT_LSB]),
    .o_chan     (o_meas_chan),
    .o_start    (o_meas_start)
  );

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_addr_nack_foreign: assert property (
    st_r == RDF_ST_ADDR && byte_end && !addr_hit && !start_c
    && !stop_c |=> st_r == RDF_ST_IGNORE && !o_sda_oe)
    else $error("foreign address was not ignored");
  a_addr_ack_own: assert property (
    st_r == RDF_ST_ADDR && byte_end && addr_hit && !start_c
    && !stop_c |=> o_sda_oe && st_r == RDF_ST_ADDR_AK)
    else $error("own address was not acked");
  a_reserved_zero_bits: assert property (
    o_fault_status[`RDF_RSVD_HI_BIT] == 1'b0
    && o_fault_status[`RDF_RSVD_LO_BIT] == 1'b0)
    else $error("reserved status bit read as one");
  a_reset_clears_reg: assert property (
    @(posedge i_core_clk) disable iff (1'b0)
    !i_rst_n |=> o_fault_status == `RDF_FAULT_RST)
    else $error("reset did not clear fault register");
  a_stop_releases_bus: assert property (
    stop_c |=> st_r == RDF_ST_IDLE && !o_sda_oe)
    else $error("stop did not release bus");
  a_tx_stable_high: assert property (
    st_r == RDF_ST_TX && scl && pin_d_r[1] && !stop_c && !start_c
    |=> $stable(o_sda_oe))
    else $error("data changed while clock high");

  c_own_addr_ack: cover property (st_r == RDF_ST_ADDR_AK && o_sda_oe);
  c_read_byte_done: cover property (st_r == RDF_ST_TX_AK ##1 scl_rise);
  c_fault_seen: cover property (o_fault_status != 8'h00);

endmodule

//--- rtl/rdf_pkg.sv
package rdf_pkg;

  // Bus slave states
  typedef enum logic [2:0] {
    RDF_ST_IDLE    = 3'b000,
    RDF_ST_ADDR    = 3'b001,
    RDF_ST_ADDR_AK = 3'b010,
    RDF_ST_CMD     = 3'b011,
    RDF_ST_CMD_AK  = 3'b100,
    RDF_ST_TX      = 3'b101,
    RDF_ST_TX_AK   = 3'b110,
    RDF_ST_IGNORE  = 3'b111
  } rdf_state_t;

  // Bus pins as seen from the device
  typedef struct packed {
    logic scl;
    logic sda;
  } rdf_bus_pins_t;

  // Per-channel diode comparator levels from the front end
  typedef struct packed {
    logic [5:0] diode_open;
    logic [5:0] anode_high;
  } rdf_diode_flags_t;

endpackage

//--- rtl/rdf_sequencer.sv
`include "rdf_cfg.svh"

// Steps the measurement slot through local and remote channels
module rdf_sequencer
  import rdf_pkg::*;
#(
  parameter int N_CH      = 6,
  parameter int SLOT_CYC  = `RDF_SLOT_CYCLES
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_rst_n,
  input  wire logic [N_CH-1:0] i_fault,
  output logic [2:0]           o_chan,
  output logic                 o_start
);

  // Elaboration check on sizes
  if (N_CH < 1 || N_CH > 6 || SLOT_CYC < 2 || SLOT_CYC > 65536)
    $error("rdf_sequencer: unsupported N_CH or SLOT_CYC");

  logic [15:0]     cnt_r;     // Slot timer
  logic [2:0]      next_chan; // Next channel to visit
  logic [N_CH-1:0] fault_d_r; // Helper copy for checking

  // Next channel, skipping remote channels flagged faulty
  function automatic logic [2:0] pick_next(input logic [2:0] cur,
                                           input logic [N_CH-1:0] flt);
    logic [2:0] c;
    logic       found;
    c     = cur;
    found = 1'b0;
    for (int k = 0; k <= N_CH; k++) begin
      if (!found) begin
        c = (c == 3'(N_CH)) ? 3'h0 : 3'(c + 3'h1);
        // Local channel is always measured
        if (c == 3'h0 || !flt[c - 3'h1]) begin
          found = 1'b1;
        end
      end
    end
    return c;
  endfunction

  assign next_chan = pick_next(o_chan, i_fault);

  // Slot timer and channel step
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_r     <= 16'h0000;
      o_chan    <= 3'h0;
      o_start   <= 1'b0;
      fault_d_r <= '0;
    end else begin
      fault_d_r <= i_fault;
      o_start   <= (cnt_r == 16'(SLOT_CYC - 1));
      if (cnt_r == 16'(SLOT_CYC - 1)) begin
        cnt_r  <= 16'h0000;
        o_chan <= next_chan;
      end else begin
        cnt_r  <= cnt_r + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_skip_faulted_chan: assert property (
    o_start && o_chan != 3'h0 |-> !fault_d_r[o_chan - 3'h1])
    else $error("measured a channel flagged faulty");
  a_slot_start_spacing: assert property (
    o_start |=> !o_start)
    else $error("slot starts back to back");
  c_skip_seen: cover property (
    o_start && o_chan != 3'h0 && fault_d_r != '0);

endmodule
